// ==== nvm_pkg.sv ====
// Purpose: Shared constants and types for the I2C setting switch
// Assumes: 25 MHz system clock
// Notes:   Setting registers are 6 bits wide; upper two bits read zero
package nvm_pkg;
	localparam int          NVM_CLK_HZ      = 25000000;
	localparam int          NVM_BUSY_US     = 3600;
	localparam int          NVM_BUSY_CYC    = (NVM_CLK_HZ / 1000000) * NVM_BUSY_US;
	localparam int          NVM_NUM_REGS    = 4;
	localparam int          NVM_MAX_BURST   = 4;
	localparam int          NVM_DATA_W      = 6;
	localparam logic [7:0]  NVM_OFS_SET0    = 8'h00;
	localparam logic [7:0]  NVM_OFS_SET3    = 8'h03;
	localparam logic [7:0]  NVM_OFS_SNAP    = 8'hff;
	localparam logic [3:0]  NVM_CMD_HI      = 4'hf;
	localparam logic [1:0]  NVM_SRC_ALWAYS  = 2'h0;
	localparam logic [1:0]  NVM_SRC_PIN     = 2'h1;
	localparam logic [1:0]  NVM_SRC_INPUTS  = 2'h2;
	localparam logic [5:0]  NVM_SET_RESET   = 6'h00;
	localparam logic [6:0]  NVM_DEV_ADDR    = 7'h50; // Arbitrary bus address

	// Output source override held from a source command
	typedef struct packed {
		logic       active;
		logic [1:0] mode;
		logic [1:0] reg_sel;
	} nvm_src_t;

	typedef enum logic [6:0] {
		NVM_IDLE  = 7'h01,
		NVM_ADDR  = 7'h02,
		NVM_AACK  = 7'h04,
		NVM_WBYTE = 7'h08,
		NVM_WACK  = 7'h10,
		NVM_RBYTE = 7'h20,
		NVM_RACK  = 7'h40
	} nvm_state_t;
endpackage

// ==== nvm_switch.sv ====
// What this block does
// - Control address plus later STOP programs byte
// - Up to four burst bytes, committed at STOP
// - Fifth byte refused, whole burst discarded
// - Pointer advances after each setting access
// - Pointer FFh reads input pins, top zero
// - Pointers 00h-03h read matching register
// - After source command, refuse data bytes
// - Read sends data chosen by stored pointer
// - Ignore own address 3.6 ms after write
// - Block programming while supply not good
// - Guard pin high: refuse data, keep contents
// - Settings read zero until first programmed
// - Select high, no override: outputs follow inputs
// - Select low, no override: bus-selected register
// - Source command overrides the select pin, except mode 1 (NVM_SRC_PIN) where the pin still picks inputs
// - Reset initialises volatile state and machine
// - After reset, select low shows register 0
// - Control byte decode: addresses and source commands
// - Reserved control bytes are not acknowledged
//
// Purpose: I2C slave holding four 6-bit settings that drive six outputs
// Assumes: SCL/SDA are slow against i_clk; settings model non-volatile cells
// Notes:   Open-drain outputs: output enable high pulls the line low
`timescale 1ns/1ps
module nvm_switch
	import nvm_pkg::*;
#(
	parameter int BUSY_CYC = NVM_BUSY_CYC
)(
	input  wire logic       i_clk,
	input  wire logic       i_reset,
	input  wire logic       i_scl,
	input  wire logic       i_sda,
	input  wire logic       i_write_guard,
	input  wire logic       i_supply_good,
	input  wire logic       i_source_select_pin,
	input  wire logic [5:0] i_external_setting_inputs,
	output logic            o_sda,
	output logic            o_sda_oe,
	output logic [5:0]      o_setting_outputs,
	output logic [5:0]      o_setting_outputs_oe
);

	// ----------------------------------------------------------------
	// Input synchronisers
	// ----------------------------------------------------------------
	logic [1:0] scl_s_q, sda_s_q, grd_s_q, pwr_s_q, sel_s_q;
	logic [5:0] ext_m_q, ext_q;
	logic       scl_d1_q, sda_d1_q;

	// Two flops per pin; the first stage is never looked at, and SCL and SDA add a third
	always_ff @(posedge i_clk) begin
		scl_s_q <= {scl_s_q[0], i_scl};
		sda_s_q <= {sda_s_q[0], i_sda};
		grd_s_q <= {grd_s_q[0], i_write_guard};
		pwr_s_q <= {pwr_s_q[0], i_supply_good};
		sel_s_q <= {sel_s_q[0], i_source_select_pin};
		ext_m_q <= i_external_setting_inputs;
		ext_q   <= ext_m_q;
		scl_d1_q <= scl_s_q[1];
		sda_d1_q <= sda_s_q[1];
	end

	// Third stage holds the previous level; pin to strobe takes two clocks
	logic scl, sda, scl_rise, scl_fall, start_c, stop_c;
	assign scl      = scl_s_q[1];
	assign sda      = sda_s_q[1];
	assign scl_rise = scl & ~scl_d1_q;
	assign scl_fall = ~scl & scl_d1_q;
	assign start_c  = scl & scl_d1_q & sda_d1_q & ~sda;
	assign stop_c   = scl & scl_d1_q & ~sda_d1_q & sda;

	// ----------------------------------------------------------------
	// Bus state
	// ----------------------------------------------------------------
	nvm_state_t        state_q;
	logic [7:0]        shift_q;
	logic [2:0]        bit_q;
	logic              is_read_q;
	logic              ack_q;
	logic              ctrl_seen_q;
	logic [7:0]        ptr_q;
	logic              ptr_cmd_q;
	logic [2:0]        burst_q;
	logic              burst_bad_q;
	logic [5:0]        pend_q [NVM_NUM_REGS];
	logic [3:0]        pend_v_q;
	logic [5:0]        set_q [NVM_NUM_REGS];
	nvm_src_t          src_q;
	logic [1:0]        last_sel_q;
	logic [22:0]       busy_q;
	logic              sda_oe_q;
	logic              full_q;

	logic [7:0] rx_byte;
	logic       ctrl_addr_ok, ctrl_src_ok;
	assign rx_byte      = {shift_q[6:0], sda};
	// control decode
	// 1111xx11 stays reserved and is refused, except FFh which sets the input-pin pointer
	assign ctrl_addr_ok = (rx_byte[7:2] == 6'h00);
	assign ctrl_src_ok  = (rx_byte[7:4] == NVM_CMD_HI) && (rx_byte[1:0] != 2'h3);

	// Read data picked by the stored pointer
	// Register 1 is reached through the 00h-03h range like the rest
	logic [7:0] rd_byte;
	always_comb begin
		rd_byte = 8'h00;
		if (ptr_q == NVM_OFS_SNAP)
			rd_byte = {2'h0, ext_q};
		else if (ptr_q <= NVM_OFS_SET3)
			rd_byte = {2'h0, set_q[ptr_q[1:0]]};
	end

	// ----------------------------------------------------------------
	// Byte engine: shifts bits, decides acknowledges
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			state_q     <= NVM_IDLE;
			shift_q     <= 8'h00;
			bit_q       <= 3'h0;
			is_read_q   <= 1'b0;
			ack_q       <= 1'b0;
			ctrl_seen_q <= 1'b0;
			sda_oe_q    <= 1'b0;
			full_q      <= 1'b0;
		end else if (start_c) begin
			state_q  <= NVM_ADDR;
			bit_q    <= 3'h0;
			sda_oe_q <= 1'b0;
			full_q   <= 1'b0;
		end else if (stop_c) begin
			state_q  <= NVM_IDLE;
			sda_oe_q <= 1'b0;
		end else begin
			case (state_q)
				NVM_IDLE: begin
					sda_oe_q <= 1'b0;
				end
				NVM_ADDR, NVM_WBYTE: begin
					// Eighth rise marks a whole byte; the shift value cannot, since 00h is legal
					if (scl_rise) begin
						shift_q <= rx_byte;
						bit_q   <= bit_q + 3'h1;
						full_q  <= (bit_q == 3'h7);
					end
					if (scl_fall && full_q) begin
						full_q <= 1'b0;
						if (state_q == NVM_ADDR) begin
							ack_q     <= (shift_q[7:1] == NVM_DEV_ADDR) && (busy_q == '0);
							is_read_q <= shift_q[0];
							ctrl_seen_q <= 1'b0;
							sda_oe_q  <= (shift_q[7:1] == NVM_DEV_ADDR) && (busy_q == '0);
							state_q   <= NVM_AACK;
						end else begin
							sda_oe_q <= ack_q;
							state_q  <= NVM_WACK;
						end
					end
				end
				NVM_AACK, NVM_WACK: begin
					if (scl_fall) begin
						sda_oe_q <= 1'b0;
						shift_q  <= 8'h00;
						// A refused byte leaves the bus alone until the next START
						if (!ack_q)
							state_q <= NVM_IDLE;
						else if (is_read_q) begin
							shift_q  <= rd_byte;
							sda_oe_q <= ~rd_byte[7];
							state_q  <= NVM_RBYTE;
						end else
							state_q <= NVM_WBYTE;
					end
				end
				NVM_RBYTE: begin
					if (scl_fall) begin
						bit_q <= bit_q + 3'h1;
						shift_q <= {shift_q[6:0], 1'b0};
						sda_oe_q <= (bit_q == 3'h7) ? 1'b0 : ~shift_q[6];
						if (bit_q == 3'h7)
							state_q <= NVM_RACK;
					end
				end
				NVM_RACK: begin
					// Master acknowledge taken on the rise; none ends the read
					if (scl_rise)
						ack_q <= ~sda;
					if (scl_fall) begin
						if (ack_q) begin
							shift_q  <= rd_byte;
							sda_oe_q <= ~rd_byte[7];
							state_q  <= NVM_RBYTE;
						end else
							state_q <= NVM_IDLE;
					end
				end
				default: state_q <= NVM_IDLE;
			endcase
			// Acknowledge choice for a received write byte
			// Decided on the eighth rise so the answer is ready before SCL falls
			if ((state_q == NVM_WBYTE) && scl_rise && bit_q == 3'h7) begin
				ctrl_seen_q <= 1'b1;
				if (!ctrl_seen_q)
					ack_q <= ctrl_addr_ok || (rx_byte == NVM_OFS_SNAP) || ctrl_src_ok;
				else
					ack_q <= !ptr_cmd_q && !grd_s_q[1] && (burst_q < 3'(NVM_MAX_BURST))
						&& (ptr_q <= NVM_OFS_SET3);
			end
		end
	end

	// Byte-complete strobe for the write path
	// A START or STOP on the same edge wins over the byte
	logic wbyte_done;
	assign wbyte_done = (state_q == NVM_WBYTE) && scl_rise && bit_q == 3'h7 && !start_c && !stop_c;

	// ----------------------------------------------------------------
	// Pointer, burst collection and commit
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			ptr_q       <= NVM_OFS_SET0;
			ptr_cmd_q   <= 1'b0;
			burst_q     <= 3'h0;
			burst_bad_q <= 1'b0;
			pend_v_q    <= 4'h0;
			src_q       <= '0;
			last_sel_q  <= 2'h0;
			busy_q      <= '0;
		end else begin
			if (busy_q != '0)
				busy_q <= busy_q - 23'h1;
			if (start_c) begin
				burst_q     <= 3'h0;
				burst_bad_q <= 1'b0;
				pend_v_q    <= 4'h0;
			end
			if (wbyte_done && !ctrl_seen_q) begin
				if (ctrl_addr_ok || rx_byte == NVM_OFS_SNAP) begin
					ptr_q     <= rx_byte;
					ptr_cmd_q <= 1'b0;
				end else if (ctrl_src_ok) begin
					ptr_cmd_q <= 1'b1;
					src_q     <= '{active: 1'b1, mode: rx_byte[1:0], reg_sel: rx_byte[3:2]};
					last_sel_q <= rx_byte[3:2];
				end
			end else if (wbyte_done && !ptr_cmd_q && ptr_q <= NVM_OFS_SET3) begin
				if (grd_s_q[1] || burst_q >= 3'(NVM_MAX_BURST))
					burst_bad_q <= !grd_s_q[1];
				else begin
					pend_v_q[ptr_q[1:0]] <= 1'b1;
					burst_q <= burst_q + 3'h1;
					ptr_q   <= {6'h00, ptr_q[1:0] + 2'h1};
				end
			end
			// reads advance pointer too, as the last bit of a byte leaves.
			// Advancing at the acknowledge would reload the same register next.
			if (state_q == NVM_RBYTE && scl_fall && bit_q == 3'h7 && !start_c && !stop_c
				&& ptr_q <= NVM_OFS_SET3)
				ptr_q <= {6'h00, ptr_q[1:0] + 2'h1};
			// busy window after commit
			// Supply or guard lost before STOP also cancels the commit
			if (stop_c && pend_v_q != 4'h0 && !burst_bad_q && pwr_s_q[1] && !grd_s_q[1]) begin
				busy_q   <= 23'(BUSY_CYC);
				pend_v_q <= 4'h0;
			end
		end
	end

	// Pending data; the top two bits of each byte are dropped
	// Slots carry no reset; pend_v_q alone says which hold data
	always_ff @(posedge i_clk) begin
		if (wbyte_done && ctrl_seen_q && ptr_q <= NVM_OFS_SET3)
			pend_q[ptr_q[1:0]] <= rx_byte[5:0];
	end

	// Setting cells; reset models factory contents of all zeros
	// Each cell takes only its own slot, so a short burst leaves the rest alone
	genvar gi;
	generate
		for (gi = 0; gi < NVM_NUM_REGS; gi++) begin : g_set
			always_ff @(posedge i_clk) begin
				if (i_reset)
					set_q[gi] <= NVM_SET_RESET;
				// commit on STOP, supply gate, guard gate
				else if (stop_c && pend_v_q[gi] && !burst_bad_q && pwr_s_q[1] && !grd_s_q[1])
					set_q[gi] <= pend_q[gi];
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// Output source and pin drivers
	// ----------------------------------------------------------------
	// Selection without an override is volatile, so a power cycle returns to register 0
	logic [5:0] out_val;
	always_comb begin
		// bus-selected register, register 0 after reset
		out_val = set_q[last_sel_q];
		if (sel_s_q[1])
			out_val = ext_q;
		if (src_q.active) begin
			case (src_q.mode)
				NVM_SRC_ALWAYS: out_val = set_q[src_q.reg_sel];
				NVM_SRC_PIN:    out_val = sel_s_q[1] ? ext_q : set_q[src_q.reg_sel];
				NVM_SRC_INPUTS: out_val = ext_q;
				default:        out_val = ext_q;
			endcase
		end
	end

	// Registered drivers; a zero bit pulls its open-drain line low
	// Data stays low and only the enable moves, as open-drain pins need
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			o_setting_outputs    <= 6'h00;
			o_setting_outputs_oe <= 6'h00;
			o_sda                <= 1'b0;
			o_sda_oe             <= 1'b0;
		end else begin
			o_setting_outputs    <= 6'h00;
			o_setting_outputs_oe <= ~out_val;
			o_sda                <= 1'b0;
			o_sda_oe             <= sda_oe_q;
		end
	end

endmodule

// ==== nvm_switch_checker.sv ====
// Purpose: Port-level checks of the setting switch
// Assumes: Master keeps SCL low five cycles of each bit
// Notes:   A run of SCL-high cycles stands in for bus-free detection
`timescale 1ns/1ps
module nvm_switch_checker
	import nvm_pkg::*;
#(
	parameter int BUSY_CYC = NVM_BUSY_CYC
)(
	input wire logic       i_clk,
	input wire logic       i_reset,
	input wire logic       i_scl,
	input wire logic       i_sda,
	input wire logic       i_write_guard,
	input wire logic       i_supply_good,
	input wire logic       i_source_select_pin,
	input wire logic [5:0] i_external_setting_inputs,
	input wire logic       o_sda,
	input wire logic       o_sda_oe,
	input wire logic [5:0] o_setting_outputs,
	input wire logic [5:0] o_setting_outputs_oe
);
	// ----------------------------------------
	// Helper and checks
	// ----------------------------------------
	logic [3:0] scl_high_q;

	// Saturating count of SCL-high cycles; only START, STOP and an idle bus hold it long
	always_ff @(posedge i_clk) begin
		if (i_reset || !i_scl) begin
			scl_high_q <= 4'h0;
		end else if (scl_high_q != 4'hf) begin
			scl_high_q <= scl_high_q + 4'h1;
		end
	end

	default clocking @(posedge i_clk); endclocking
	default disable iff (i_reset);

	a_out_lines: assert property (o_setting_outputs == 6'h00)
		else $error("setting output data not low");
	a_sda_level: assert property (o_sda == 1'b0)
		else $error("sda data not low");
	a_wake_quiet: assert property ($fell(i_reset) |-> !o_sda_oe [*4])
		else $error("sda driven after reset");
	a_wake_reg: assert property ($fell(i_reset) && !i_source_select_pin |-> ##[1:6] (o_setting_outputs_oe == 6'h3f))
		else $error("outputs not register 0 after reset");
	a_drive_hold: assert property ($rose(o_sda_oe) |-> o_sda_oe [*3])
		else $error("sda drive too short");
	a_release_hold: assert property ($fell(o_sda_oe) |=> $stable(o_sda_oe) [*2])
		else $error("sda release too short");
	a_change_low: assert property ($changed(o_sda_oe) |-> !i_scl)
		else $error("sda changed with scl high");
	a_idle_free: assert property (scl_high_q >= 4'hc |-> !o_sda_oe)
		else $error("sda driven on free bus");
endmodule

bind nvm_switch nvm_switch_checker #(.BUSY_CYC(BUSY_CYC)) u_chk (.i_clk(i_clk), .i_reset(i_reset), .i_scl(i_scl),
	.i_sda(i_sda), .i_write_guard(i_write_guard), .i_supply_good(i_supply_good),
	.i_source_select_pin(i_source_select_pin), .i_external_setting_inputs(i_external_setting_inputs),
	.o_sda(o_sda), .o_sda_oe(o_sda_oe), .o_setting_outputs(o_setting_outputs),
	.o_setting_outputs_oe(o_setting_outputs_oe));

// ==== nvm_master.sv ====
// Purpose: Behavioural bus master for the setting switch
// Assumes: Eight clock cycles per bit, 320 ns
// Notes:   SCL stands high between frames
`timescale 1ns/1ps
module nvm_master (
	input  wire logic i_clk,
	input  wire logic i_sda,
	output logic      o_scl,
	output logic      o_sda
);
	// Idle bus at time zero
	initial begin
		o_scl = 1'b1;
		o_sda = 1'b1;
	end

	task automatic hc(input int n);
		repeat (n) @(posedge i_clk);
	endtask

	// Data moves one cycle after SCL falls so the slave sees clock first
	task automatic bit_x(input logic b, output logic r);
		o_scl <= 1'b0;
		hc(1);
		o_sda <= b;
		hc(4);
		o_scl <= 1'b1;
		hc(3);
		r = i_sda;
	endtask

	task automatic start();
		hc(1);
		o_sda <= 1'b0;
		hc(4);
	endtask

	task automatic stop();
		o_scl <= 1'b0;
		hc(1);
		o_sda <= 1'b0;
		hc(4);
		o_scl <= 1'b1;
		hc(3);
		o_sda <= 1'b1;
		hc(8);
	endtask

	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_x(d[i], r);
		end
		bit_x(1'b1, r);
		ack = ~r;
	endtask

	task automatic rbyte(input logic more, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_x(1'b1, d[i]);
		end
		bit_x(~more, r);
	endtask
endmodule

// ==== tb_top.sv ====
// Purpose: Self-checking bench for the setting switch
// Assumes: Master model paces the bus at 320 ns per bit
// Notes:   Short busy count keeps the run brief
`timescale 1ns/1ps
module tb_top;
	import nvm_pkg::*;
	localparam int         BUSY = 200;
	localparam logic [7:0] AW   = {NVM_DEV_ADDR, 1'b0};
	logic       clk   = 1'b0;
	logic       rst   = 1'b1;
	logic       guard = 1'b0;
	logic       sup   = 1'b1;
	logic       sel   = 1'b0;
	logic [5:0] pins  = 6'h2d;
	logic       scl, sda_m, sda_o, sda_oe, k;
	logic [5:0] outs, outs_oe;
	logic [7:0] q[$];
	logic [7:0] a;
	int         errors = 0;
	int         checks_done = 0;
	wire        sda_w = sda_m & ~sda_oe; // Pulled-up wired-AND line

	always #20 clk = ~clk;

	nvm_switch #(.BUSY_CYC(BUSY)) dut (.i_clk(clk), .i_reset(rst), .i_scl(scl), .i_sda(sda_w),
		.i_write_guard(guard), .i_supply_good(sup), .i_source_select_pin(sel),
		.i_external_setting_inputs(pins), .o_sda(sda_o), .o_sda_oe(sda_oe),
		.o_setting_outputs(outs), .o_setting_outputs_oe(outs_oe));
	nvm_master m (.i_clk(clk), .i_sda(sda_w), .o_scl(scl), .o_sda(sda_m));

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			errors++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// One write frame of queue q; ack of byte i lands in a[i]
	task automatic wr();
		a = 8'h00;
		m.start();
		foreach (q[i]) begin
			m.wbyte(q[i], k);
			a[i] = k;
		end
		m.stop();
	endtask

	task automatic rd(input logic [7:0] p, input logic [7:0] e[$]);
		logic [7:0] d;
		q = '{AW, p};
		wr();
		m.start();
		m.wbyte(AW | 8'h01, k);
		foreach (e[i]) begin
			m.rbyte(i < e.size() - 1, d);
			chk("read data", d, e[i]);
		end
		m.stop();
	endtask

	// Outputs are open drain, so the pin level is the inverse of the enable
	task automatic outs_is(input logic [5:0] e);
		repeat (6) @(posedge clk);
		chk("outputs", {2'h0, outs_oe}, {2'h0, ~e});
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset();
		outs_is(6'h00);
		rd(8'h00, '{8'h00, 8'h00, 8'h00, 8'h00});
		$display("reset test done");
	endtask

	task automatic t_burst();
		q = '{AW, 8'h00, 8'hc1, 8'he2, 8'h83, 8'h24};
		wr();
		chk("burst acks", a, 8'h3f);
		m.start();
		m.wbyte(AW, k);
		m.stop();
		chk("busy ack", {7'h00, k}, 8'h00);
		repeat (BUSY + 20) @(posedge clk);
		outs_is(6'h01);
		rd(8'h00, '{8'h01, 8'h22, 8'h03, 8'h24});
		rd(8'h03, '{8'h24, 8'h01});
		rd(8'h02, '{8'h03});
		$display("burst test done");
	endtask

	// Fifth data byte refused; an immediate read proves nothing went busy
	task automatic t_over();
		q = '{AW, 8'h02, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15};
		wr();
		chk("overrun acks", a, 8'h3f);
		rd(8'h02, '{8'h03});
		$display("overrun test done");
	endtask

	task automatic t_guard();
		guard <= 1'b1;
		q = '{AW, 8'h00, 8'h3e};
		wr();
		chk("guarded acks", a, 8'h03);
		guard <= 1'b0;
		sup <= 1'b0;
		wr();
		sup <= 1'b1;
		repeat (BUSY + 20) @(posedge clk);
		rd(8'h00, '{8'h01});
		$display("guard test done");
	endtask

	task automatic t_source();
		sel <= 1'b1;
		outs_is(6'h2d);
		q = '{AW, 8'hf8, 8'h00};
		wr();
		chk("command acks", a, 8'h03);
		outs_is(6'h03);
		sel <= 1'b0;
		q = '{AW, 8'hf2};
		wr();
		outs_is(6'h2d);
		q = '{AW, 8'hf5};
		wr();
		outs_is(6'h22);
		sel <= 1'b1;
		outs_is(6'h2d);
		q = '{AW, 8'h04};
		wr();
		chk("reserved ack", a, 8'h01);
		q = '{AW, 8'hf3};
		wr();
		chk("reserved ack", a, 8'h01);
		rd(8'hff, '{8'h2d, 8'h2d});
		pins <= 6'h12;
		rd(8'hff, '{8'h12});
		$display("source test done");
	endtask

	// Main sequence
	initial begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_burst();
		t_over();
		t_guard();
		t_source();
		results();
	end

	// Hang guard
	initial begin
		repeat (100000) @(posedge clk);
		errors++;
		results();
	end
endmodule
